// ---- hdl/gsl_pkg.sv ----
// package for the gauge threshold and led status block
// assumes pressure in units of 0.1 mtorr and a 100 mhz pclk
package gsl_pkg;

  // clock
  localparam int unsigned CLK_HZ        = 100_000_000;

  // times in milliseconds, as specified
  localparam int unsigned T_8TH_MS      = 125;
  localparam int unsigned T_SHORT_MS    = 50;
  localparam int unsigned T_CHECK_MS    = 100;
  localparam int unsigned T_HOLD_MS     = 3000;
  localparam int unsigned T_FORCE_MS    = 1000;
  localparam int unsigned T_TOGGLE_MS   = 2000;

  // cycle counts derived from the times
  localparam logic [31:0] CYC_8TH    = 32'(CLK_HZ / 1000 * T_8TH_MS);
  localparam logic [31:0] CYC_SHORT  = 32'(CLK_HZ / 1000 * T_SHORT_MS);
  localparam logic [31:0] CYC_CHECK  = 32'(CLK_HZ / 1000 * T_CHECK_MS);
  localparam logic [31:0] CYC_HOLD   = 32'(CLK_HZ / 1000 * T_HOLD_MS);
  localparam logic [31:0] CYC_FORCE  = 32'(CLK_HZ / 1000 * T_FORCE_MS);
  localparam logic [31:0] CYC_TOGGLE = 32'(CLK_HZ / 1000 * T_TOGGLE_MS);

  // pressure levels, lsb = 0.1 mtorr
  localparam logic [31:0] P_0P01_TORR = 32'h0000_0064;  // 0.01 torr
  localparam logic [31:0] P_1_TORR    = 32'h0000_2710;  // 1 torr
  localparam logic [31:0] P_10_TORR   = 32'h0001_86a0;  // 10 torr
  localparam logic [31:0] P_700_TORR  = 32'h006a_cfc0;  // 700 torr
  localparam logic [31:0] P_800_TORR  = 32'h007a_1200;  // 800 torr
  localparam logic [31:0] P_1000_TORR = 32'h0098_9680;  // 1000 torr
  localparam logic [31:0] HYST_DIV    = 32'h0000_000a;  // 10 percent

  // apb register byte offsets
  localparam logic [7:0]  OFS_CTRL      = 8'h00;
  localparam logic [7:0]  OFS_UPPER_THR = 8'h04;
  localparam logic [7:0]  OFS_LOWER_THR = 8'h08;
  localparam logic [7:0]  OFS_STATUS    = 8'h0c;

  // ctrl fields
  localparam int unsigned CTRL_SERIAL_BIT = 0;
  localparam int unsigned CTRL_ZERO_BIT   = 1;

  // reset values
  localparam logic [31:0] RST_UPPER_THR = 32'h0098_9680;
  localparam logic [31:0] RST_LOWER_THR = 32'h0000_2710;

  // operating states
  typedef enum logic [1:0] {
    ST_CHECK  = 2'b00,
    ST_TOGGLE = 2'b01,
    ST_RUN    = 2'b10
  } gsl_state_e;

endpackage

// ---- hdl/gsl_top.sv ----
// gauge threshold outputs, led status patterns, zero push-button, apb registers
// assumes pressure, fault and mode flags come from logic on pclk;
// the push-button pin is asynchronous and low while pressed
`timescale 1ns/1ps

module gsl_top #(
  parameter logic [31:0] CYC_8TH    = gsl_pkg::CYC_8TH,
  parameter logic [31:0] CYC_SHORT  = gsl_pkg::CYC_SHORT,
  parameter logic [31:0] CYC_CHECK  = gsl_pkg::CYC_CHECK,
  parameter logic [31:0] CYC_HOLD   = gsl_pkg::CYC_HOLD,
  parameter logic [31:0] CYC_FORCE  = gsl_pkg::CYC_FORCE,
  parameter logic [31:0] CYC_TOGGLE = gsl_pkg::CYC_TOGGLE
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // measurement core
  input  wire logic [31:0] pressure,
  input  wire logic        comm_error,
  input  wire logic        diaphragm_fail,
  input  wire logic        thermal_fail,
  input  wire logic        calibrate_mode,
  input  wire logic        has_display,
  // push-button pin, low while pressed
  input  wire logic        button_n,
  // open-drain threshold pins
  input  wire logic        upper_threshold_output_in,
  output logic             upper_threshold_output_out,
  output logic             upper_threshold_output_oe,
  input  wire logic        lower_threshold_output_in,
  output logic             lower_threshold_output_out,
  output logic             lower_threshold_output_oe,
  // leds, yellow is red and green together
  output logic             status_led_red,
  output logic             status_led_green,
  output logic             vacuum_led_red,
  output logic             vacuum_led_green,
  // to the rest of the gauge
  output logic             zero_request,
  output logic             serial_rs485,
  output logic             running
);

  typedef struct packed {
    gsl_pkg::gsl_state_e st;
    logic [2:0]          btn_sync;
    logic                btn_held;
    logic [31:0]         sub;
    logic [3:0]          slot;
    logic [31:0]         timer;
    logic [31:0]         hold_cnt;
    logic                forcing;
    logic [31:0]         upper_thr;
    logic [31:0]         lower_thr;
    logic                upper_act;
    logic                lower_act;
    logic                serial_std;
    logic                zero_req;
    logic                st_red;
    logic                st_green;
    logic                vac_red;
    logic                vac_green;
    logic                pready;
    logic [31:0]         prdata;
    logic                pslverr;
  } gsl_regs_s;

  localparam gsl_regs_s RST = '{
    st:        gsl_pkg::ST_CHECK,
    btn_sync:  3'h7,
    btn_held:  1'b0,
    sub:       32'h0,
    slot:      4'h0,
    timer:     32'h0,
    hold_cnt:  32'h0,
    forcing:   1'b0,
    upper_thr: gsl_pkg::RST_UPPER_THR,
    lower_thr: gsl_pkg::RST_LOWER_THR,
    upper_act: 1'b0,
    lower_act: 1'b0,
    serial_std: 1'b0,
    zero_req:  1'b0,
    st_red:    1'b0,
    st_green:  1'b0,
    vac_red:   1'b0,
    vac_green: 1'b0,
    pready:    1'b0,
    prdata:    32'h0,
    pslverr:   1'b0
  };

  gsl_regs_s cur;
  gsl_regs_s next_cur;

  // hysteresis margin: a tenth of the threshold below 10 torr, else 1 torr
  function automatic logic [32:0] hyst(input logic [31:0] thr);
    logic [31:0] h;
    h = (thr < gsl_pkg::P_10_TORR) ? (thr / gsl_pkg::HYST_DIV)
                                   : gsl_pkg::P_1_TORR;
    return {1'b0, h};
  endfunction

  logic [63:0] pos1;
  logic [63:0] duty_lhs;
  logic [63:0] duty_rhs;
  logic        blink8;
  logic        blink1;
  logic        blink2;
  logic        short1;
  logic        short2;
  logic        duty_on;
  logic        adjusting;
  logic        bus_acc;
  logic        run;
  logic [32:0] p33;

  always_comb begin
    next_cur  = cur;
    pos1      = 64'h0;
    duty_lhs  = 64'h0;
    duty_rhs  = 64'h0;
    blink8    = 1'b0;
    blink1    = 1'b0;
    blink2    = 1'b0;
    short1    = 1'b0;
    short2    = 1'b0;
    duty_on   = 1'b0;
    adjusting = 1'b0;
    bus_acc   = psel & penable;
    run       = (cur.st == gsl_pkg::ST_RUN);
    p33       = {1'b0, pressure};
    next_cur.zero_req = 1'b0;

    // button: a change counts once the last two stages agree
    next_cur.btn_sync = {cur.btn_sync[1:0], button_n};
    if (cur.btn_sync[2] == cur.btn_sync[1]) begin
      next_cur.btn_held = ~cur.btn_sync[2];
    end

    // one timebase: 16 eighth-second slots make the 2 s frame, so all
    // periods share edges and never drift apart
    if (cur.sub == CYC_8TH - 32'h1) begin
      next_cur.sub  = 32'h0;
      next_cur.slot = cur.slot + 4'h1;
    end else begin
      next_cur.sub = cur.sub + 32'h1;
    end
    blink8 = (cur.sub < (CYC_8TH >> 1));
    blink1 = ~cur.slot[2];
    blink2 = ~cur.slot[3];
    short1 = (cur.slot[2:0] == 3'h0) && (cur.sub < CYC_SHORT);
    short2 = (cur.slot == 4'h0) && (cur.sub < CYC_SHORT);

    // on-time fraction of the 1 s frame equals pressure / 700 torr
    pos1     = 64'(cur.slot[2:0]) * 64'(CYC_8TH) + 64'(cur.sub);
    duty_lhs = pos1 * 64'(gsl_pkg::P_700_TORR);
    duty_rhs = 64'(pressure) * (64'(CYC_8TH) << 3);
    duty_on  = (duty_lhs < duty_rhs);

    // operating sequence
    case (cur.st)
      gsl_pkg::ST_CHECK: begin
        if (cur.timer == CYC_CHECK - 32'h1) begin
          next_cur.timer    = 32'h0;
          // a button still held must not start a zero when released late
          next_cur.hold_cnt = cur.btn_held ? CYC_HOLD : 32'h0;
          if (cur.btn_held && !has_display) begin
            next_cur.serial_std = ~cur.serial_std;
            next_cur.st         = gsl_pkg::ST_TOGGLE;
          end else begin
            next_cur.st = gsl_pkg::ST_RUN;
          end
        end else begin
          next_cur.timer = cur.timer + 32'h1;
        end
      end
      gsl_pkg::ST_TOGGLE: begin
        if (cur.timer == CYC_TOGGLE - 32'h1) begin
          next_cur.timer    = 32'h0;
          next_cur.hold_cnt = cur.btn_held ? CYC_HOLD : 32'h0;
          next_cur.st       = gsl_pkg::ST_RUN;
        end else begin
          next_cur.timer = cur.timer + 32'h1;
        end
      end
      gsl_pkg::ST_RUN: begin
        // one zero per press: the count saturates until release
        if (!cur.btn_held) begin
          next_cur.hold_cnt = 32'h0;
        end else if (cur.hold_cnt < CYC_HOLD) begin
          next_cur.hold_cnt = cur.hold_cnt + 32'h1;
          if (cur.hold_cnt == CYC_HOLD - 32'h1) begin
            next_cur.zero_req = 1'b1;
            next_cur.forcing  = 1'b1;
            next_cur.timer    = 32'h0;
          end
        end
        if (cur.forcing) begin
          if (cur.timer == CYC_FORCE - 32'h1) begin
            next_cur.forcing = 1'b0;
          end else begin
            next_cur.timer = cur.timer + 32'h1;
          end
        end
      end
      default: begin
        next_cur.st = gsl_pkg::ST_CHECK;
      end
    endcase
    adjusting = run && cur.btn_held && (cur.hold_cnt < CYC_HOLD) && !cur.forcing;

    // threshold compare with hysteresis, idle until running
    if (!run) begin
      next_cur.upper_act = 1'b0;
      next_cur.lower_act = 1'b0;
    end else begin
      if (!cur.upper_act) begin
        next_cur.upper_act = (pressure > cur.upper_thr);
      end else if (p33 + hyst(cur.upper_thr) < {1'b0, cur.upper_thr}) begin
        next_cur.upper_act = 1'b0;
      end
      if (!cur.lower_act) begin
        next_cur.lower_act = (pressure < cur.lower_thr);
      end else if (p33 > {1'b0, cur.lower_thr} + hyst(cur.lower_thr)) begin
        next_cur.lower_act = 1'b0;
      end
    end

    // led patterns, highest priority first; dark during self-check
    next_cur.st_red    = 1'b0;
    next_cur.st_green  = 1'b0;
    next_cur.vac_red   = 1'b0;
    next_cur.vac_green = 1'b0;
    if (cur.st == gsl_pkg::ST_TOGGLE) begin
      next_cur.st_green  = blink8;
      next_cur.vac_green = ~blink8;
    end else if (!run) begin
      next_cur.st_green  = 1'b0;
    end else if (cur.forcing) begin
      next_cur.st_green  = blink8;
      next_cur.vac_green = blink8;
    end else if (adjusting) begin
      next_cur.st_green  = 1'b1;
      next_cur.vac_green = blink8;
    end else if (diaphragm_fail) begin
      next_cur.st_red  = 1'b1;
      next_cur.vac_red = 1'b1;
    end else if (thermal_fail) begin
      next_cur.st_red  = 1'b1;
      next_cur.vac_red = blink2;
    end else if (comm_error) begin
      next_cur.st_red  = blink2;
      next_cur.vac_red = ~blink2;
    end else if (calibrate_mode) begin
      next_cur.st_green  = blink1;
      next_cur.vac_green = blink1;
    end else begin
      next_cur.st_green = 1'b1;
      if (pressure > gsl_pkg::P_1000_TORR) begin
        next_cur.vac_red   = blink1;
        next_cur.vac_green = blink1;
      end else if (pressure > gsl_pkg::P_800_TORR) begin
        next_cur.vac_red   = 1'b1;
        next_cur.vac_green = 1'b1;
      end else if (pressure >= gsl_pkg::P_700_TORR) begin
        next_cur.vac_green = 1'b1;
      end else if (pressure < gsl_pkg::P_0P01_TORR) begin
        next_cur.vac_green = short2;
      end else if (pressure < gsl_pkg::P_1_TORR) begin
        next_cur.vac_green = short1;
      end else begin
        next_cur.vac_green = duty_on;
      end
    end

    // apb: ready rises one cycle into the access phase; the write lands
    // and the transfer closes on the edge that sees ready high
    if (bus_acc && !cur.pready) begin
      next_cur.pready  = 1'b1;
      next_cur.pslverr = 1'b0;
      next_cur.prdata  = 32'h0;
      case (paddr)
        gsl_pkg::OFS_CTRL: begin
          next_cur.prdata[gsl_pkg::CTRL_SERIAL_BIT] = cur.serial_std;
        end
        gsl_pkg::OFS_UPPER_THR: begin
          next_cur.prdata = cur.upper_thr;
        end
        gsl_pkg::OFS_LOWER_THR: begin
          next_cur.prdata = cur.lower_thr;
        end
        gsl_pkg::OFS_STATUS: begin
          next_cur.prdata[4:0] = {cur.btn_held, run, cur.serial_std,
                                  cur.lower_act, cur.upper_act};
        end
        default: begin
          next_cur.pslverr = 1'b1;
        end
      endcase
      if (paddr == gsl_pkg::OFS_STATUS && pwrite) begin
        next_cur.pslverr = 1'b1;  // status is read-only
      end
    end else if (bus_acc && cur.pready) begin
      next_cur.pready  = 1'b0;
      next_cur.pslverr = 1'b0;
      if (pwrite && !cur.pslverr) begin
        case (paddr)
          gsl_pkg::OFS_CTRL: begin
            next_cur.serial_std = pwdata[gsl_pkg::CTRL_SERIAL_BIT];
            // a software zero only counts once running
            if (pwdata[gsl_pkg::CTRL_ZERO_BIT] && run) begin
              next_cur.zero_req = 1'b1;
            end
          end
          gsl_pkg::OFS_UPPER_THR: begin
            next_cur.upper_thr = pwdata;
          end
          gsl_pkg::OFS_LOWER_THR: begin
            next_cur.lower_thr = pwdata;
          end
          default: begin
            next_cur.pslverr = 1'b0;
          end
        endcase
      end
    end else begin
      next_cur.pready  = 1'b0;
      next_cur.pslverr = 1'b0;
    end
  end

  // all state in one register; ce low freezes every field
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur <= RST;
    end else if (ce) begin
      cur <= next_cur;
    end
  end

  // open drain: the data level stays low, the enable pulls the pin
  assign upper_threshold_output_out = 1'b0;
  assign upper_threshold_output_oe  = cur.upper_act;
  assign lower_threshold_output_out = 1'b0;
  assign lower_threshold_output_oe  = cur.lower_act;

  assign pready           = cur.pready;
  assign prdata           = cur.prdata;
  assign pslverr          = cur.pslverr;
  assign status_led_red   = cur.st_red;
  assign status_led_green = cur.st_green;
  assign vacuum_led_red   = cur.vac_red;
  assign vacuum_led_green = cur.vac_green;
  assign zero_request     = cur.zero_req;
  assign serial_rs485     = cur.serial_std;
  // the run state alone has its upper code bit set, so the pin needs no decode gate
  assign running          = cur.st[1];

endmodule

// ---- dv/gsl_field_model.sv ----
// far side of the block: pull-ups on both threshold pins and the zero push-button
// assumes the bench sets press; the pin levels feed back into the block
`timescale 1ns/1ps
module gsl_field_model (
  input  wire logic upper_oe,
  input  wire logic lower_oe,
  input  wire logic press,
  output logic      upper_pin,
  output logic      lower_pin,
  output logic      button_n
);
  // a released open-drain pin floats up to the pull-up level
  assign upper_pin = upper_oe ? 1'b0 : 1'b1;
  assign lower_pin = lower_oe ? 1'b0 : 1'b1;
  // the button shorts its pin to ground while pressed
  assign button_n = press ? 1'b0 : 1'b1;
endmodule

// ---- dv/gsl_top_assertions.sv ----
// concurrent checks on the ports of the threshold and led status block
// assumes one clock domain; bound to every gsl_top instance
`timescale 1ns/1ps
module gsl_top_assertions #(
  parameter logic [31:0] CYC_FORCE = gsl_pkg::CYC_FORCE
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        ce,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [31:0] pressure,
  input wire logic        comm_error,
  input wire logic        diaphragm_fail,
  input wire logic        thermal_fail,
  input wire logic        button_n,
  input wire logic        upper_threshold_output_out,
  input wire logic        upper_threshold_output_oe,
  input wire logic        lower_threshold_output_out,
  input wire logic        lower_threshold_output_oe,
  input wire logic        status_led_red,
  input wire logic        status_led_green,
  input wire logic        vacuum_led_red,
  input wire logic        vacuum_led_green,
  input wire logic        zero_request,
  input wire logic        running
);
  logic [31:0] thr_u;
  logic [31:0] thr_l;
  logic [31:0] quiet;
  logic        act;
  logic        calm;

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // release margin: relative below 10 torr, absolute above
  function automatic logic [32:0] hyst(input logic [31:0] t);
    return (t < gsl_pkg::P_10_TORR) ? 33'(t / gsl_pkg::HYST_DIV) : 33'(gsl_pkg::P_1_TORR);
  endfunction

  // mirror accepted threshold writes; quiet counts cycles free of button and zeroing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      thr_u <= gsl_pkg::RST_UPPER_THR;
      thr_l <= gsl_pkg::RST_LOWER_THR;
      quiet <= 32'h0;
    end else begin
      if (psel && penable && pready && pwrite && !pslverr &&
          paddr == gsl_pkg::OFS_UPPER_THR) thr_u <= pwdata;
      if (psel && penable && pready && pwrite && !pslverr &&
          paddr == gsl_pkg::OFS_LOWER_THR) thr_l <= pwdata;
      quiet <= (!button_n || zero_request) ? 32'h0 : quiet + {31'h0, quiet != 32'hffff_ffff};
    end
  end

  // patterns of faults are only judged once button patterns cannot overlay them
  assign act  = ce && running;
  assign calm = act && quiet > CYC_FORCE + 32'h8;

  a_upper_set: assert property (act && pressure > thr_u |=> upper_threshold_output_oe)
    else $error("upper output not active above threshold");
  a_upper_hold: assert property (act && upper_threshold_output_oe &&
      {1'b0, pressure} + hyst(thr_u) >= {1'b0, thr_u} |=> upper_threshold_output_oe)
    else $error("upper output released inside hysteresis");
  a_lower_set: assert property (act && pressure < thr_l |=> lower_threshold_output_oe)
    else $error("lower output not active below threshold");
  a_lower_clear: assert property (act && {1'b0, pressure} > {1'b0, thr_l} + hyst(thr_l)
      |=> !lower_threshold_output_oe)
    else $error("lower output not released past margin");
  a_pins_open_drain: assert property (!upper_threshold_output_out &&
      !lower_threshold_output_out)
    else $error("threshold pin driven high");
  a_selfcheck_idle: assert property ($rose(presetn) |-> (!running &&
      !upper_threshold_output_oe && !lower_threshold_output_oe) [*8])
    else $error("activity during self-check");
  a_zero_pulse: assert property (zero_request && ce |-> running ##1 !zero_request)
    else $error("zero request not a single pulse while running");
  a_diaph_red: assert property (calm && diaphragm_fail |=> status_led_red && vacuum_led_red
      && !status_led_green && !vacuum_led_green)
    else $error("diaphragm fault not steady red");
  a_comm_anti: assert property (calm && comm_error && !diaphragm_fail && !thermal_fail
      |=> status_led_red != vacuum_led_red && !status_led_green)
    else $error("comm error leds not alternating red");
  a_apb_wait: assert property (psel && penable && !pready |=> pready ##1 !pready)
    else $error("apb answer not after one wait state");

  c_zero: cover property (zero_request);
  c_upper: cover property ($rose(upper_threshold_output_oe));
  c_comm: cover property (calm && comm_error && status_led_red);
endmodule

// ---- dv/test_gsl_top.sv ----
// self-checking bench for the threshold and led status block
// assumes shortened counts; the field model supplies pins and button
`timescale 1ns/1ps
module test_gsl_top;
  localparam logic [31:0] CYC_8TH = 32'h10;
  localparam logic [31:0] CYC_FORCE = 32'h28;
  logic        pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, press, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, pressure, rd;
  logic        comm_error, diaphragm_fail, thermal_fail, calibrate_mode, has_display;
  logic        button_n, upper_threshold_output_in, lower_threshold_output_in;
  logic        upper_threshold_output_out, upper_threshold_output_oe;
  logic        lower_threshold_output_out, lower_threshold_output_oe;
  logic        status_led_red, status_led_green, vacuum_led_red, vacuum_led_green;
  logic        zero_request, serial_rs485, running;
  int          failures, checked, k, n_sr, n_sg, n_vr, n_vg, n_eq;
  logic [31:0] tp [7] = '{32'h186a0, 32'h30d41, 32'h2e631, 32'h2e62f, 32'hc34f, 32'hd6d8,
                          32'hd6d9};
  logic [6:0]  eu = 7'b0000110;
  logic [6:0]  el = 7'b0110000;

  gsl_top #(.CYC_8TH(CYC_8TH), .CYC_SHORT(32'h4), .CYC_CHECK(32'h14), .CYC_HOLD(32'h64),
    .CYC_FORCE(CYC_FORCE), .CYC_TOGGLE(32'h40)) i_dut (.*);
  gsl_field_model i_field (.upper_oe(upper_threshold_output_oe),
    .lower_oe(lower_threshold_output_oe), .press(press),
    .upper_pin(upper_threshold_output_in), .lower_pin(lower_threshold_output_in),
    .button_n(button_n));

  // free-running 100 mhz clock
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic results();
    $display("checks %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one apb transfer; request held until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin @(posedge pclk); k++; end while (pready !== 1'b1 && k < 50);
    rd = prdata; err = pslverr;
    if (k >= 50) failures++;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  task automatic rst(input logic held, input logic disp);
    presetn <= 1'b0; press <= held; has_display <= disp;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
  endtask

  // count lit cycles of each led, and cycles where both leds show the same colour
  task automatic watch(input int n);
    n_sr = 0; n_sg = 0; n_vr = 0; n_vg = 0; n_eq = 0;
    repeat (n) begin
      @(posedge pclk);
      n_sr += int'(status_led_red === 1'b1); n_sg += int'(status_led_green === 1'b1);
      n_vr += int'(vacuum_led_red === 1'b1); n_vg += int'(vacuum_led_green === 1'b1);
      n_eq += int'(status_led_red === vacuum_led_red && status_led_green === vacuum_led_green);
    end
  endtask

  task automatic leds(input logic [31:0] p, input logic [3:0] f, input int n,
                      input int esr, esg, evr, evg, eeq);
    pressure <= p;
    {comm_error, diaphragm_fail, thermal_fail, calibrate_mode} <= f;
    repeat (3) @(posedge pclk);
    watch(n);
    chk(n_sr, esr); chk(n_sg, esg); chk(n_vr, evr); chk(n_vg, evg); chk(n_eq, eeq);
  endtask

  // stop a hung run
  initial begin
    #300_000;
    failures++;
    results();
  end

  initial begin
    ce = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
    pwdata = 32'h0; pressure = 32'h0073_f780;
    {comm_error, diaphragm_fail, thermal_fail, calibrate_mode} = 4'h0;
    rst(1'b0, 1'b1);
    @(posedge pclk);
    chk(running, 1'b0);
    k = 0;
    while (running !== 1'b1 && k < 100) begin @(posedge pclk); k++; end
    chk(32'(running === 1'b1 && k >= 18), 32'h1);
    apb(1'b0, 8'h04, 32'h0); chk(rd, gsl_pkg::RST_UPPER_THR);
    apb(1'b0, 8'h08, 32'h0); chk(rd, gsl_pkg::RST_LOWER_THR);
    apb(1'b0, 8'h10, 32'h0); chk(err, 1'b1);
    apb(1'b1, 8'h0c, 32'h3); chk(err, 1'b1);
    apb(1'b1, 8'h04, 32'h0003_0d40); apb(1'b1, 8'h08, 32'h0000_c350);
    apb(1'b0, 8'h04, 32'h0); chk(rd, 32'h0003_0d40);
    for (int i = 0; i < 7; i++) begin
      pressure <= tp[i];
      repeat (2) @(posedge pclk);
      chk(upper_threshold_output_in, !eu[i]);
      chk(lower_threshold_output_in, !el[i]);
    end
    leds(32'h0073_f780, 4'h0, 256, 0, 256, 0, 256, 256);
    leds(32'h0081_b320, 4'h0, 256, 0, 256, 256, 256, 0);
    leds(32'h00a0_37a0, 4'h0, 256, 0, 256, 128, 128, 0);
    leds(32'h0035_67e0, 4'h0, 256, 0, 256, 0, 128, 128);
    leds(32'h0000_1388, 4'h0, 512, 0, 512, 0, 16, 16);
    leds(32'h0000_0032, 4'h0, 512, 0, 512, 0, 8, 8);
    leds(32'h0073_f780, 4'he, 256, 256, 0, 256, 0, 256);
    leds(32'h0073_f780, 4'ha, 512, 512, 0, 256, 0, 256);
    leds(32'h0073_f780, 4'h9, 512, 256, 0, 256, 0, 0);
    leds(32'h0073_f780, 4'h1, 256, 0, 128, 0, 128, 256);
    leds(32'h0073_f780, 4'h0, 16, 0, 16, 0, 16, 16);
    press <= 1'b1;
    repeat (8) @(posedge pclk);
    watch(64); chk(n_sg, 64); chk(n_vg, 32); chk(n_sr + n_vr, 0);
    k = 0;
    while (zero_request !== 1'b1 && k < 100) begin @(posedge pclk); k++; end
    chk(32'(72 + k >= 100 && 72 + k <= 110), 32'h1);
    repeat (2) @(posedge pclk);
    watch(32); chk(n_eq, 32); chk(n_vg, 16);
    rst(1'b1, 1'b0);
    repeat (26) @(posedge pclk);
    watch(32); chk(n_eq, 0); chk(n_sg, 16); chk(n_vg, 16);
    press <= 1'b0;
    k = 0;
    while (running !== 1'b1 && k < 200) begin @(posedge pclk); k++; end
    chk(serial_rs485, 1'b1);
    // software zero and serial select through the control word, then readback
    apb(1'b1, gsl_pkg::OFS_CTRL, 32'h0000_0002);
    @(posedge pclk);
    chk(zero_request, 1'b1);
    chk(serial_rs485, 1'b0);
    apb(1'b0, gsl_pkg::OFS_STATUS, 32'h0); chk(rd, 32'h0000_0008);
    apb(1'b0, gsl_pkg::OFS_CTRL, 32'h0); chk(rd, 32'h0000_0000);
    results();
  end
endmodule

bind gsl_top gsl_top_assertions #(.CYC_FORCE(CYC_FORCE)) i_chk (.*);
